// ==== rtl/tpo_pkg.sv ====
// Constants for the timer prescale and overflow flag block
package tpo_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_MODE   = 6'h00;
  localparam logic [5:0] IDX_CNT    = 6'h04;
  localparam logic [5:0] IDX_CTL1   = 6'h06;
  localparam logic [5:0] IDX_IEN    = 6'h0c;
  localparam logic [5:0] IDX_CTL2   = 6'h0d;
  localparam logic [5:0] IDX_FLG1   = 6'h0e;
  localparam logic [5:0] IDX_FLG2   = 6'h0f;
  localparam logic [5:0] IDX_CH_LO  = 6'h10;
  localparam logic [5:0] IDX_CH_HI  = 6'h1f;
  localparam logic [5:0] IDX_PACC   = 6'h20;
  // Field positions
  localparam int CTL1_TEN_BIT  = 7;
  localparam int CTL1_FFCA_BIT = 4;
  localparam int CTL2_TOI_BIT  = 7;
  localparam int CTL2_COMPARE7_COUNTER_RESET_ENABLE_BIT = 3;
  localparam int FLG2_TOF_BIT  = 7;
  localparam int PACC_PULSE_ACCUM_ENABLE_BIT = 6;
  // Values
  localparam logic [15:0] CNT_MAX   = 16'hffff;
  localparam logic [15:0] CNT_ZERO  = 16'h0000;
  localparam logic [2:0]  SEL_RESET = 3'h0;
  localparam logic [31:0] RD_ZERO   = 32'h0000_0000;
endpackage

// ==== rtl/tpo_timer.sv ====
// Timer counter with prescaler, modulus reset, channel and overflow flags, APB slave
//
// Operation
// - Overflow irq when flag set and enabled
// - Compare-7 resets counter when enabled
// - Compare value zero holds counter at zero
// - Compare value max never sets overflow
// - Modulus period is value*divide plus one
// - Prescale select divides by two-power
// - New prescale waits for zero prescaler
// - Capture or compare sets channel flag
// - Write one clears flag when enabled
// - Writing zero leaves flags unchanged
// - Fast clear on capture-channel read or compare-channel write
// - Fast clear overflow on counter access
// - Counter rollover sets overflow flag
// - Overflow flag bit seven, write-one clear
// - Channel irq enables gate channel flags
//
// The implementer's own choice: the APB register port.
`timescale 1ns/100ps
module tpo_timer
  import tpo_pkg::*;
#(
  parameter int NCH = 8
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst_b,
  // APB slave
  input  wire logic             i_psel,
  input  wire logic             i_penable,
  input  wire logic             i_pwrite,
  input  wire logic [7:0]       i_paddr,
  input  wire logic [31:0]      i_pwdata,
  output logic                  o_pready,
  output logic [31:0]           o_prdata,
  output logic                  o_pslverr,
  // Channel capture events, one-cycle pulses
  input  wire logic [NCH-1:0]   i_capture,
  // Interrupt and counter view
  output logic                  o_irq,
  output logic [15:0]           o_count
);

  typedef struct packed {
    logic [15:0]          cnt;
    logic [6:0]           presc;
    logic [2:0]           sel_act;
    logic [2:0]           sel;
    logic                 timer_enable_bit;
    logic                 ffca;
    logic                 overflow_irq_enable;
    logic                 compare7_counter_reset_enable;
    logic                 pulse_accum_enable;
    logic [NCH-1:0]       ios;
    logic [NCH-1:0]       ien;
    logic [NCH-1:0]       flg;
    logic                 overflow_flag;
    logic [NCH-1:0][15:0] tc;
    logic                 upd;
    logic                 pready;
    logic [31:0]          prdata;
    logic                 pslverr;
    logic                 irq;
  } tpo_state_t;

  tpo_state_t st_r;
  tpo_state_t st_nxt;

  function automatic logic [6:0] pmask(input logic [2:0] sel);
    pmask = 7'((8'h01 << sel) - 8'h01);
  endfunction

  function automatic logic is_chan(input logic [5:0] idx);
    is_chan = (idx >= IDX_CH_LO) && (idx <= IDX_CH_HI) && !idx[0];
  endfunction

  logic [5:0]     idx;
  logic [2:0]     ch;
  logic           acc;
  logic           wr;
  logic           rd;
  logic           tick;
  logic           modrst;
  logic           clr_en;
  logic [NCH-1:0] set_flg;
  logic [NCH-1:0] clr_flg;
  logic           set_tof;
  logic           clr_tof;
  logic           mapped;
  logic [31:0]    rdata;

  assign idx    = i_paddr[7:2];
  assign ch     = idx[3:1];
  // Act only on the completing access cycle
  assign acc    = i_psel && i_penable && st_r.pready;
  assign wr     = acc && i_pwrite;
  assign rd     = acc && !i_pwrite;
  assign tick   = st_r.timer_enable_bit && ((st_r.presc & pmask(st_r.sel_act)) == pmask(st_r.sel_act));
  // One bus clock after the counter reaches the channel-7 value
  assign modrst = st_r.timer_enable_bit && st_r.compare7_counter_reset_enable && (st_r.cnt == st_r.tc[NCH-1]);
  assign clr_en = st_r.timer_enable_bit || st_r.pulse_accum_enable;

  always_comb begin
    mapped = 1'b1;
    rdata  = RD_ZERO;
    unique case (idx)
      IDX_MODE: rdata = {24'h0, st_r.ios};
      IDX_CNT:  rdata = {16'h0, st_r.cnt};
      IDX_CTL1: rdata = {24'h0, st_r.timer_enable_bit, 2'h0, st_r.ffca, 4'h0};
      IDX_IEN:  rdata = {24'h0, st_r.ien};
      IDX_CTL2: rdata = {24'h0, st_r.overflow_irq_enable, 3'h0, st_r.compare7_counter_reset_enable, st_r.sel};
      IDX_FLG1: rdata = {24'h0, st_r.flg};
      IDX_FLG2: rdata = {24'h0, st_r.overflow_flag, 7'h0};
      IDX_PACC: rdata = {24'h0, 1'b0, st_r.pulse_accum_enable, 6'h0};
      default: begin
        if (is_chan(idx)) begin
          rdata = {16'h0, st_r.tc[ch]};
        end else begin
          mapped = 1'b0;
        end
      end
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    set_flg = '0;
    clr_flg = '0;
    set_tof = 1'b0;
    clr_tof = 1'b0;
    // Bus: one wait state, every output registered
    st_nxt.pready  = i_psel && i_penable && !st_r.pready;
    st_nxt.pslverr = i_psel && i_penable && !st_r.pready && !mapped;
    if (i_psel && i_penable && !st_r.pready) begin
      st_nxt.prdata = i_pwrite ? RD_ZERO : rdata;
    end
    // Prescaler and counter
    st_nxt.upd = 1'b0;
    if (st_r.presc == 7'h00) begin
      st_nxt.sel_act = st_r.sel;
    end
    if (modrst) begin
      st_nxt.cnt   = CNT_ZERO;
      st_nxt.presc = 7'h00;
      st_nxt.upd   = (st_r.cnt != CNT_ZERO);
    end else if (st_r.timer_enable_bit) begin
      st_nxt.presc = 7'(st_r.presc + 7'h01) & pmask(st_r.sel_act);
      if (tick) begin
        st_nxt.cnt = st_r.cnt + 16'h0001;
        st_nxt.upd = 1'b1;
        set_tof    = (st_r.cnt == CNT_MAX);
      end
    end
    // Channel events
    for (int i = 0; i < NCH; i++) begin
      if (st_r.ios[i]) begin
        set_flg[i] = st_r.upd && (st_r.cnt == st_r.tc[i]);
      end else if (i_capture[i]) begin
        st_nxt.tc[i] = st_r.cnt;
        set_flg[i]   = 1'b1;
      end
    end
    // Register writes and clearing
    if (wr) begin
      unique case (idx)
        IDX_MODE: st_nxt.ios = i_pwdata[NCH-1:0];
        IDX_CNT:  clr_tof    = st_r.ffca;
        IDX_CTL1: begin
          st_nxt.timer_enable_bit  = i_pwdata[CTL1_TEN_BIT];
          st_nxt.ffca = i_pwdata[CTL1_FFCA_BIT];
        end
        IDX_IEN:  st_nxt.ien = i_pwdata[NCH-1:0];
        IDX_CTL2: begin
          st_nxt.overflow_irq_enable  = i_pwdata[CTL2_TOI_BIT];
          st_nxt.compare7_counter_reset_enable = i_pwdata[CTL2_COMPARE7_COUNTER_RESET_ENABLE_BIT];
          st_nxt.sel  = i_pwdata[2:0];
        end
        IDX_FLG1: clr_flg = clr_en ? i_pwdata[NCH-1:0] : '0;
        IDX_FLG2: clr_tof = clr_en && i_pwdata[FLG2_TOF_BIT];
        IDX_PACC: st_nxt.pulse_accum_enable = i_pwdata[PACC_PULSE_ACCUM_ENABLE_BIT];
        default: begin
          if (is_chan(idx) && st_r.ios[ch]) begin
            st_nxt.tc[ch] = i_pwdata[15:0];
            clr_flg[ch]   = st_r.ffca;
          end
        end
      endcase
    end
    if (rd) begin
      if (idx == IDX_CNT) begin
        clr_tof = st_r.ffca;
      end else if (is_chan(idx) && !st_r.ios[ch]) begin
        clr_flg[ch] = st_r.ffca;
      end
    end
    // A new event wins over a clear in the same cycle
    st_nxt.flg = (st_r.flg & ~clr_flg) | set_flg;
    st_nxt.overflow_flag = (st_r.overflow_flag & ~clr_tof) | set_tof;
    st_nxt.irq = |(st_nxt.flg & st_nxt.ien) || (st_nxt.overflow_flag && st_nxt.overflow_irq_enable);
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_pready  = st_r.pready;
  assign o_prdata  = st_r.prdata;
  assign o_pslverr = st_r.pslverr;
  assign o_irq     = st_r.irq;
  assign o_count   = st_r.cnt;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  property p_irq;
    1 |=> o_irq == $past(|(st_nxt.flg & st_nxt.ien) || (st_nxt.overflow_flag && st_nxt.overflow_irq_enable));
  endproperty
  a_irq: assert property (p_irq) else $error("irq disagrees with flags");

  property p_modrst;
    st_r.timer_enable_bit && st_r.compare7_counter_reset_enable && st_r.cnt == st_r.tc[NCH-1] |=> st_r.cnt == CNT_ZERO && st_r.presc == 7'h00;
  endproperty
  a_modrst: assert property (p_modrst) else $error("modulus reset missed");

  property p_hold0;
    st_r.timer_enable_bit && st_r.compare7_counter_reset_enable && st_r.tc[NCH-1] == CNT_ZERO && st_r.cnt == CNT_ZERO && !wr |=> st_r.cnt == CNT_ZERO;
  endproperty
  a_hold0: assert property (p_hold0) else $error("counter left zero");

  property p_nomaxovf;
    st_r.compare7_counter_reset_enable && st_r.tc[NCH-1] == CNT_MAX && st_r.cnt == CNT_MAX && !st_r.overflow_flag |=> !st_r.overflow_flag;
  endproperty
  a_nomaxovf: assert property (p_nomaxovf) else $error("overflow set by modulus reset");

  property p_selsync;
    $changed(st_r.sel_act) |-> $past(st_r.presc) == 7'h00;
  endproperty
  a_selsync: assert property (p_selsync) else $error("prescale changed mid-count");

  property p_ovf;
    tick && !modrst && st_r.cnt == CNT_MAX |=> st_r.overflow_flag && st_r.cnt == CNT_ZERO;
  endproperty
  a_ovf: assert property (p_ovf) else $error("rollover lost");

  property p_inc;
    tick && !modrst |=> st_r.cnt == 16'($past(st_r.cnt) + 16'h0001);
  endproperty
  a_inc: assert property (p_inc) else $error("counter did not advance");

  property p_w0;
    wr && idx == IDX_FLG1 && i_pwdata[NCH-1:0] == '0 |=> ($past(st_r.flg) & ~st_r.flg) == '0;
  endproperty
  a_w0: assert property (p_w0) else $error("zero write cleared a flag");

  property p_w1c;
    wr && idx == IDX_FLG1 && clr_en && i_pwdata[0] && !set_flg[0] |=> !st_r.flg[0];
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared");

  property p_fastcnt;
    acc && idx == IDX_CNT && st_r.ffca && !set_tof |=> !st_r.overflow_flag;
  endproperty
  a_fastcnt: assert property (p_fastcnt) else $error("fast clear missed");

  // Interrupt level follows the registered flags and enables in the same cycle
  property p_irq_lvl;
    o_irq == (|(st_r.flg & st_r.ien) || (st_r.overflow_flag && st_r.overflow_irq_enable));
  endproperty
  a_irq_lvl: assert property (p_irq_lvl) else $error("irq level wrong");

  property p_toi_off;
    st_r.overflow_flag && !st_r.overflow_irq_enable && (st_r.flg & st_r.ien) == '0 |-> !o_irq;
  endproperty
  a_toi_off: assert property (p_toi_off) else $error("overflow irq not inhibited");

  property p_ien_block;
    (st_r.flg & st_r.ien) == '0 && !st_r.overflow_flag |-> !o_irq;
  endproperty
  a_ien_block: assert property (p_ien_block) else $error("masked channel raised irq");

  // Without the modulus enable the counter must free-run
  property p_nocre;
    !st_r.compare7_counter_reset_enable |-> !modrst;
  endproperty
  a_nocre: assert property (p_nocre) else $error("reset without enable");

  property p_div1;
    st_r.timer_enable_bit && st_r.sel_act == SEL_RESET |-> tick;
  endproperty
  a_div1: assert property (p_div1) else $error("divide by one missed a tick");

  property p_stall;
    !st_r.timer_enable_bit |=> st_r.cnt == $past(st_r.cnt);
  endproperty
  a_stall: assert property (p_stall) else $error("counter moved while disabled");

  property p_settof;
    set_tof |=> st_r.overflow_flag;
  endproperty
  a_settof: assert property (p_settof) else $error("overflow flag not set");

  // Overflow flag is sticky until software clears it
  property p_tof_hold;
    st_r.overflow_flag && !clr_tof |=> st_r.overflow_flag;
  endproperty
  a_tof_hold: assert property (p_tof_hold) else $error("overflow flag dropped");

  property p_tof_clr;
    wr && idx == IDX_FLG2 && clr_en && i_pwdata[FLG2_TOF_BIT] && !set_tof |=> !st_r.overflow_flag;
  endproperty
  a_tof_clr: assert property (p_tof_clr) else $error("overflow flag not cleared");

  property p_tof_noen;
    wr && idx == IDX_FLG2 && !clr_en && st_r.overflow_flag |=> st_r.overflow_flag;
  endproperty
  a_tof_noen: assert property (p_tof_noen) else $error("overflow cleared while disabled");

  // Channel flags only fall through a bus access
  property p_flg_hold;
    !acc |=> ($past(st_r.flg) & ~st_r.flg) == '0;
  endproperty
  a_flg_hold: assert property (p_flg_hold) else $error("channel flag dropped");

  property p_w1c_noen;
    wr && idx == IDX_FLG1 && !clr_en |=> ($past(st_r.flg) & ~st_r.flg) == '0;
  endproperty
  a_w1c_noen: assert property (p_w1c_noen) else $error("flag cleared while disabled");

  property p_fastch;
    rd && is_chan(idx) && !st_r.ios[ch] && st_r.ffca && !set_flg[ch] |=> !st_r.flg[$past(ch)];
  endproperty
  a_fastch: assert property (p_fastch) else $error("fast channel clear missed");

  property p_cap;
    !st_r.ios[0] && i_capture[0] |=> st_r.flg[0];
  endproperty
  a_cap: assert property (p_cap) else $error("capture flag not set");

  c_ovf:    cover property (set_tof);
  c_modrst: cover property (modrst ##1 st_r.cnt == CNT_ZERO);
  c_irq:    cover property ($rose(o_irq));
  c_fast:   cover property (acc && st_r.ffca);
  c_presc:  cover property ($changed(st_r.sel_act));
endmodule

// ==== verif/tb_top.sv ====
// Self-checking bench for the timer prescale and overflow flag block
`timescale 1ns/100ps
module tb_top;
  import tpo_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_rst_b = 1'b0;
  logic        i_psel = 1'b0;
  logic        i_penable = 1'b0;
  logic        i_pwrite = 1'b0;
  logic [7:0]  i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0;
  logic [7:0]  i_capture = 8'h00;
  logic        o_pready;
  logic [31:0] o_prdata;
  logic        o_pslverr;
  logic        o_irq;
  logic [15:0] o_count;
  logic [15:0] c0;
  logic [7:0]  cap;
  logic [32:0] exp_q[$];
  int          n_fail = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          seed = 65254;
  int          n;

  always #5 i_clk = ~i_clk;

  tpo_timer #(.NCH(8)) tpo_timer_inst (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
    .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_capture(i_capture),
    .o_irq(o_irq), .o_count(o_count));

  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("compares=%0d mismatches=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Request held until pready is seen at an edge; read data is checked by the monitor
  task automatic apb(input logic w, input logic [5:0] idx, input logic [31:0] d, input logic [32:0] e);
    if (!w)
      exp_q.push_back(e);
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= {idx, 2'b00};
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do @(posedge i_clk); while (o_pready !== 1'b1);
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d, 33'h0);
  endtask

  task automatic rd(input logic [5:0] idx, input logic [31:0] d);
    apb(1'b0, idx, 32'h0, {1'b0, d});
  endtask

  task automatic idle(input int k);
    repeat (k) @(posedge i_clk);
  endtask

  // Bounded only by the global timeout, since the counter may take a full wrap
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (o_pready === 1'b1 && i_pwrite === 1'b0 && exp_q.size() > 0)
      chk({o_pslverr, o_prdata}, exp_q.pop_front());
    if (cyc > 100000) begin
      n_fail++;
      report_and_stop();
    end
  end

  initial begin
    cap = 8'($random(seed)) & 8'h7f | 8'h03;
    idle(20);
    i_rst_b <= 1'b1;
    rd(IDX_CTL2, 32'h0);
    apb(1'b0, 6'h01, 32'h0, {1'b1, 32'h0});
    @(posedge i_clk);
    i_capture <= cap;
    @(posedge i_clk);
    i_capture <= 8'h00;
    idle(2);
    rd(IDX_FLG1, {24'h0, cap});
    wr(IDX_FLG1, {24'h0, cap});
    rd(IDX_FLG1, {24'h0, cap});
    wr(IDX_FLG1, 32'h0);
    rd(IDX_FLG1, {24'h0, cap});
    wr(IDX_IEN, 32'h1);
    idle(3);
    chk(o_irq, 33'h1);
    wr(IDX_IEN, 32'h0);
    idle(3);
    chk(o_irq, 33'h0);
    wr(IDX_PACC, 32'h40);
    wr(IDX_FLG1, 32'h1);
    rd(IDX_FLG1, {24'h0, cap & 8'hfe});
    wr(IDX_PACC, 32'h0);
    // Timer stalled so the captured value is known to be zero
    wr(IDX_CTL1, 32'h10);
    rd(IDX_CH_LO + 6'h02, 32'h0);
    rd(IDX_FLG1, {24'h0, cap & 8'hfc});
    // Modulus set up while the counter still stands at zero
    wr(IDX_MODE, 32'h80);
    wr(IDX_CH_HI - 6'h01, 32'h0);
    wr(IDX_CTL2, 32'h08);
    wr(IDX_CTL1, 32'h80);
    wr(IDX_FLG1, 32'hff);
    rd(IDX_FLG1, 32'h0);
    idle(50);
    repeat (8) begin
      @(posedge i_clk);
      chk(o_count, 33'h0);
    end
    wr(IDX_CH_HI - 6'h01, 32'h9);
    wr(IDX_CTL2, 32'h0a);
    idle(300);
    while (o_count == 16'h0000) @(posedge i_clk);
    while (o_count != 16'h0000) @(posedge i_clk);
    n = 0;
    while (o_count == 16'h0000) begin
      @(posedge i_clk);
      n++;
    end
    while (o_count != 16'h0000) begin
      @(posedge i_clk);
      n++;
    end
    chk(33'(n), 33'd37);
    rd(IDX_FLG1, 32'h80);
    for (int s = 0; s < 8; s++) begin
      wr(IDX_CTL2, 32'(s));
      idle(300);
      c0 = o_count;
      idle(16 << s);
      chk(33'(o_count - c0), 33'h10);
    end
    wr(IDX_CTL2, 32'h0);
    while (o_count != 16'hffff) @(posedge i_clk);
    idle(3);
    rd(IDX_FLG2, 32'h80);
    chk(o_irq, 33'h0);
    wr(IDX_CTL2, 32'h80);
    idle(3);
    chk(o_irq, 33'h1);
    wr(IDX_CTL1, 32'h90);
    wr(IDX_CNT, 32'h0);
    rd(IDX_FLG2, 32'h0);
    idle(3);
    chk(o_irq, 33'h0);
    report_and_stop();
  end
endmodule
